// >>> inc/ata_cmd_defs.svh
`ifndef ATA_CMD_DEFS_SVH
`define ATA_CMD_DEFS_SVH
// What this block does
// - security word: bit 8 is level, bits 15-9 and 7-6 read zero
// - security word bits 5..0: erase, expired, frozen, locked, enabled, supported
// - security word is always readable when the feature is supported
// - idle command sets busy, enters idle, clears busy, interrupts
// - idle with nonzero count loads the power-down timer with count times 5 ms and arms it
// - idle with zero count disables automatic power-down
// - idle immediate enters idle and interrupts, ignoring sector count
// - init drive parameters takes sectors per track from sector count
// - init drive parameters takes head count minus one from low nibble
// - media lock and unlock do nothing and end with aborted command
// - nop always ends with aborted command
// - read buffer returns sector buffer contents by programmed transfer
// - programmed read: data request and interrupt together in the next cycle, with no busy or fill step
// - read dma moves 1 to 256 sectors, count zero means 256
// - read dma starts at sector number, cylinder and head address
// - read dma sets busy and buffers data before the transfer
// - dma request only while buffered read data is available
// - read dma interrupts only at completion or on an error
// - after read dma the address registers hold the last sector read
// - on read dma error stop and hold the failing sector address
`define OFF_DATA     12'h000
`define OFF_ERROR    12'h004
`define OFF_SCOUNT   12'h008
`define OFF_SNUM     12'h00c
`define OFF_CYLLO    12'h010
`define OFF_CYLHI    12'h014
`define OFF_DRVHD    12'h018
`define OFF_CMD      12'h01c
`define OFF_SECURITY 12'h020
`define OFF_GEOM     12'h024
`define OFF_POWER    12'h028
`define CMD_IDLE_A   8'h97
`define CMD_IDLE_B   8'he3
`define CMD_IDLEI_A  8'h95
`define CMD_IDLEI_B  8'he1
`define CMD_INIT     8'h91
`define CMD_LOCK     8'hde
`define CMD_UNLOCK   8'hdf
`define CMD_NOP      8'h00
`define CMD_RDBUF    8'he4
`define CMD_RDDMA    8'hc8
`define ST_BSY       7
`define ST_DRDY      6
`define ST_DRQ       3
`define ST_ERR       0
`define ER_UNC       6
`define ER_ABRT      2
`define DH_LBA       6
`define DH_DEV       4
`define SEC_MASK     16'h013f
`define SECTOR_WORDS 9'h100
`define PD_UNIT_MS   5
`define CLK_MHZ      100
`define PD_TICK      (`PD_UNIT_MS * 1000 * `CLK_MHZ)
`define RST_SPT      8'h3f
`define RST_HEADS    4'hf
`endif

// >>> inc/cmd_pkg.sv
package cmd_pkg;
	typedef enum logic [3:0] {
		S_RDY  = 4'h1,
		S_EXEC = 4'h2,
		S_PIO  = 4'h4,
		S_DMA  = 4'h8
	} state_t;
endpackage

// >>> design/ata_cmd.sv
`timescale 1ns/1ns
`include "ata_cmd_defs.svh"
module ata_cmd #(
	parameter int          TICK_CYCLES = `PD_TICK,
	parameter logic [0:0]  DEV_NUM     = 1'b0
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// ata dma pins
	output logic             dmareq,
	input  wire logic        dmack_n,
	input  wire logic        iord_n,
	output logic      [15:0] dd_out,
	output logic             intrq,
	// media read port
	output logic             media_req,
	output logic      [27:0] media_addr,
	output logic             media_lba,
	input  wire logic        media_valid,
	input  wire logic [15:0] media_data,
	input  wire logic        media_err,
	// power state
	output logic             power_down,
	output logic             auto_pd_on
);
	// tick count must fit the 20-bit divider
	if (TICK_CYCLES < 2 || TICK_CYCLES > 1048575) begin : g_tick_range
		$error("TICK_CYCLES out of range");
	end

	cmd_pkg::state_t st;
	logic [15:0] sbuf [0:255];
	logic [7:0]  features;
	logic [7:0]  err_reg;
	logic [7:0]  scount;
	logic [7:0]  snum;
	logic [7:0]  cyllo;
	logic [7:0]  cylhi;
	logic [7:0]  drvhd;
	logic        err_st;
	logic [15:0] security;
	logic [7:0]  spt;
	logic [3:0]  heads;
	logic [8:0]  remain;
	logic [8:0]  wcnt;
	logic [8:0]  rcnt;
	logic [7:0]  pptr;
	logic [19:0] tick;
	logic [7:0]  pd_units;
	logic [7:0]  pd_load;
	logic [2:0]  iord_s;
	logic [1:0]  dmack_s;
	logic        rd_acc;
	logic        wr_acc;
	logic        cmd_wr;
	logic        sel_ok;
	logic        strobe;
	logic        sec_done;
	logic        last_sec;
	logic [7:0]  cmd;
	logic [7:0]  status;
	logic        mapped;
	logic        ready_st;

	assign pready   = 1'b1;
	assign rd_acc   = psel & penable & ~pwrite;
	assign wr_acc   = psel & penable & pwrite;
	assign ready_st = (st == cmd_pkg::S_RDY);
	assign cmd      = pwdata[7:0];
	assign sel_ok   = (drvhd[`DH_DEV] == DEV_NUM);
	assign cmd_wr   = wr_acc && (paddr == `OFF_CMD) && ready_st && sel_ok;
	assign sec_done = (wcnt == `SECTOR_WORDS) && (rcnt == `SECTOR_WORDS);
	assign last_sec = (remain == 9'h001);

	always_comb begin
		mapped = 1'b1;
		unique case (paddr)
			`OFF_DATA, `OFF_ERROR, `OFF_SCOUNT, `OFF_SNUM, `OFF_CYLLO,
			`OFF_CYLHI, `OFF_DRVHD, `OFF_CMD, `OFF_SECURITY, `OFF_GEOM,
			`OFF_POWER: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	always_comb begin
		status = 8'h00;
		status[`ST_BSY]  = (st == cmd_pkg::S_EXEC) || (st == cmd_pkg::S_DMA);
		status[`ST_DRDY] = ~status[`ST_BSY];
		status[`ST_DRQ]  = (st == cmd_pkg::S_PIO);
		status[`ST_ERR]  = err_st;
	end

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			`OFF_DATA:     prdata[15:0] = (st == cmd_pkg::S_PIO) ? sbuf[pptr] : 16'h0000;
			`OFF_ERROR:    prdata[7:0]  = err_reg;
			`OFF_SCOUNT:   prdata[7:0]  = scount;
			`OFF_SNUM:     prdata[7:0]  = snum;
			`OFF_CYLLO:    prdata[7:0]  = cyllo;
			`OFF_CYLHI:    prdata[7:0]  = cylhi;
			`OFF_DRVHD:    prdata[7:0]  = drvhd;
			`OFF_CMD:      prdata[7:0]  = status;
			`OFF_SECURITY: prdata[15:0] = security & `SEC_MASK;
			`OFF_GEOM:     prdata[11:0] = {heads, spt};
			`OFF_POWER:    prdata[1:0]  = {auto_pd_on, power_down};
			default:       prdata = 32'h0000_0000;
		endcase
	end

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iord_s  <= 3'b111;
			dmack_s <= 2'b11;
		end else begin
			iord_s  <= {iord_s[1:0], iord_n};
			dmack_s <= {dmack_s[0], dmack_n};
		end
	end
	assign strobe = ~iord_s[2] & iord_s[1] & ~dmack_s[1] & (st == cmd_pkg::S_DMA);
	assign dmareq = (st == cmd_pkg::S_DMA) && (wcnt > rcnt);

	// word kept for the identify data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			security <= 16'h0000;
		end else if (wr_acc && paddr == `OFF_SECURITY) begin
			security <= pwdata[15:0] & `SEC_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			features <= 8'h00;
			scount   <= 8'h01;
			snum     <= 8'h01;
			cyllo    <= 8'h00;
			cylhi    <= 8'h00;
			drvhd    <= 8'ha0;
		end else if (st == cmd_pkg::S_DMA && sec_done && !last_sec) begin
			// address steps to the next sector
			if (drvhd[`DH_LBA]) begin
				{drvhd[3:0], cylhi, cyllo, snum} <= media_addr + 28'h000_0001;
			end else if (snum < spt) begin
				snum <= snum + 8'h01;
			end else begin
				snum <= 8'h01;
				if (drvhd[3:0] < heads) begin
					drvhd[3:0] <= drvhd[3:0] + 4'h1;
				end else begin
					drvhd[3:0] <= 4'h0;
					{cylhi, cyllo} <= {cylhi, cyllo} + 16'h0001;
				end
			end
		end else if (wr_acc && ready_st) begin
			unique case (paddr)
				`OFF_ERROR:  features <= pwdata[7:0];
				`OFF_SCOUNT: scount   <= pwdata[7:0];
				`OFF_SNUM:   snum     <= pwdata[7:0];
				`OFF_CYLLO:  cyllo    <= pwdata[7:0];
				`OFF_CYLHI:  cylhi    <= pwdata[7:0];
				`OFF_DRVHD:  drvhd    <= pwdata[7:0];
				default:     features <= features;
			endcase
		end
	end

	assign media_addr = {drvhd[3:0], cylhi, cyllo, snum};
	assign media_lba  = drvhd[`DH_LBA];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spt   <= `RST_SPT;
			heads <= `RST_HEADS;
		end else if (cmd_wr && cmd == `CMD_INIT) begin
			spt   <= scount;
			heads <= drvhd[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st        <= cmd_pkg::S_RDY;
			err_st    <= 1'b0;
			err_reg   <= 8'h00;
			remain    <= 9'h000;
			media_req <= 1'b0;
		end else begin
			media_req <= 1'b0;
			unique case (st)
				cmd_pkg::S_RDY: begin
					if (cmd_wr) begin
						err_st  <= 1'b0;
						err_reg <= 8'h00;
						unique case (cmd)
							`CMD_IDLE_A, `CMD_IDLE_B, `CMD_IDLEI_A, `CMD_IDLEI_B,
							`CMD_INIT: st <= cmd_pkg::S_EXEC;
							// buffer goes out by programmed reads
							`CMD_RDBUF: st <= cmd_pkg::S_PIO;
							`CMD_RDDMA: begin
								remain    <= (scount == 8'h00) ? 9'h100 : {1'b0, scount};
								media_req <= 1'b1;
								st        <= cmd_pkg::S_DMA;
							end
							default: begin
								err_st           <= 1'b1;
								err_reg[`ER_ABRT] <= 1'b1;
								st               <= cmd_pkg::S_EXEC;
							end
						endcase
					end
				end
				cmd_pkg::S_EXEC: st <= cmd_pkg::S_RDY;
				// drq until the host drains the buffer
				cmd_pkg::S_PIO: begin
					if (rd_acc && paddr == `OFF_DATA && pptr == 8'hff) begin
						st <= cmd_pkg::S_RDY;
					end
				end
				cmd_pkg::S_DMA: begin
					if (media_err) begin
						err_st           <= 1'b1;
						err_reg[`ER_UNC] <= 1'b1;
						st               <= cmd_pkg::S_RDY;
					end else if (sec_done) begin
						if (last_sec) begin
							st <= cmd_pkg::S_RDY;
						end else begin
							remain    <= remain - 9'h001;
							media_req <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// buffer fill and drain pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt <= 9'h000;
			rcnt <= 9'h000;
		end else if (st != cmd_pkg::S_DMA || sec_done) begin
			wcnt <= 9'h000;
			rcnt <= 9'h000;
		end else begin
			if (media_valid && wcnt < `SECTOR_WORDS) begin
				wcnt <= wcnt + 9'h001;
			end
			if (strobe && rcnt < wcnt) begin
				rcnt <= rcnt + 9'h001;
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (st == cmd_pkg::S_DMA && media_valid && wcnt < `SECTOR_WORDS) begin
			sbuf[wcnt[7:0]] <= media_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dd_out <= 16'h0000;
		end else begin
			dd_out <= sbuf[rcnt[7:0]];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pptr <= 8'h00;
		end else if (st != cmd_pkg::S_PIO) begin
			pptr <= 8'h00;
		end else if (rd_acc && paddr == `OFF_DATA) begin
			pptr <= pptr + 8'h01;
		end
	end

	// completion interrupt, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intrq <= 1'b0;
		end else if ((st == cmd_pkg::S_EXEC)
			|| (cmd_wr && cmd == `CMD_RDBUF)
			// only at the end or on error
			|| (st == cmd_pkg::S_DMA && (media_err || (sec_done && last_sec)))) begin
			intrq <= 1'b1;
		end else if ((rd_acc && paddr == `OFF_CMD) || cmd_wr) begin
			intrq <= 1'b0;
		end
	end

	// automatic power-down timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_pd_on <= 1'b0;
			pd_load    <= 8'h00;
		end else if (cmd_wr && (cmd == `CMD_IDLE_A || cmd == `CMD_IDLE_B)) begin
			auto_pd_on <= (scount != 8'h00);
			pd_load    <= scount;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick       <= 20'h00000;
			pd_units   <= 8'h00;
			power_down <= 1'b0;
		end else if (cmd_wr) begin
			tick       <= 20'h00000;
			pd_units   <= (cmd == `CMD_IDLE_A || cmd == `CMD_IDLE_B) ? scount : pd_load;
			power_down <= 1'b0;
		end else if (auto_pd_on && !power_down && ready_st) begin
			if (tick == 20'(TICK_CYCLES - 1)) begin
				tick <= 20'h00000;
				if (pd_units <= 8'h01) begin
					power_down <= 1'b1;
				end else begin
					pd_units <= pd_units - 8'h01;
				end
			end else begin
				tick <= tick + 20'h00001;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sec_rsv_zero_a: assert property (
		rd_acc && paddr == `OFF_SECURITY |-> prdata[15:9] == 7'h00 && prdata[7:6] == 2'h0)
		else $error("security reserved bits not zero");
	idle_intr_a: assert property (
		cmd_wr && cmd == `CMD_IDLE_A |=> status[`ST_BSY] ##1 !status[`ST_BSY] && intrq)
		else $error("idle did not busy then interrupt");
	pd_off_a: assert property (
		cmd_wr && cmd == `CMD_IDLE_B && scount == 8'h00 |=> !auto_pd_on ##1 !power_down)
		else $error("zero idle count left power-down armed");
	abort_err_a: assert property (
		cmd_wr && (cmd == `CMD_NOP || cmd == `CMD_LOCK) |=> ##1 err_reg[`ER_ABRT] && err_st)
		else $error("nop or lock did not abort");
	dmareq_data_a: assert property (
		dmareq |-> wcnt > rcnt && st == cmd_pkg::S_DMA)
		else $error("dma request without buffered data");
	dma_no_intr_a: assert property (
		st == cmd_pkg::S_DMA ##1 st == cmd_pkg::S_DMA |-> !$rose(intrq))
		else $error("interrupt during dma transfer");
	zero_count_a: assert property (
		cmd_wr && cmd == `CMD_RDDMA && scount == 8'h00 |=> remain == 9'h100 && media_req)
		else $error("count zero not taken as 256");
	init_geom_a: assert property (
		cmd_wr && cmd == `CMD_INIT |=> spt == $past(scount) && heads == $past(drvhd[3:0]))
		else $error("geometry not loaded");
	unsel_a: assert property (
		wr_acc && paddr == `OFF_CMD && !sel_ok && ready_st |=> ready_st && !intrq)
		else $error("command ran for other device");
	pio_drq_a: assert property (
		cmd_wr && cmd == `CMD_RDBUF |=> status[`ST_DRQ] && !status[`ST_BSY] && intrq)
		else $error("read buffer did not raise drq");
	err_hold_a: assert property (
		st == cmd_pkg::S_DMA && media_err |=> ready_st && err_st && $stable(media_addr))
		else $error("error did not stop at failing sector");

	dma_done_c: cover property (st == cmd_pkg::S_DMA && sec_done && last_sec);
	dma_err_c: cover property (st == cmd_pkg::S_DMA && media_err);
	pd_entry_c: cover property ($rose(power_down));
	pio_end_c: cover property (st == cmd_pkg::S_PIO ##1 ready_st);
endmodule

// >>> test/dma_host.sv
`timescale 1ns/1ns
module dma_host (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// dma pins
	input  wire logic        dmareq,
	input  wire logic [15:0] dd_out,
	input  wire logic        slow,
	output logic             dmack_n,
	output logic             iord_n,
	// observed data
	output int               nwords,
	output logic      [15:0] last_word
);
	initial begin
		dmack_n = 1'b1;
		iord_n = 1'b1;
		nwords = 0;
		last_word = 16'h0000;
		forever begin
			@(posedge pclk);
			if (presetn === 1'b1 && dmareq === 1'b1) begin
				dmack_n <= 1'b0;
				repeat (slow ? 6 : 1) @(posedge pclk);
				iord_n <= 1'b0;
				repeat (4) @(posedge pclk);
				last_word = dd_out;
				nwords++;
				iord_n <= 1'b1;
				// wait out the strobe synchroniser before looking again
				repeat (slow ? 9 : 4) @(posedge pclk);
				dmack_n <= 1'b1;
			end
		end
	end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ns
`include "ata_cmd_defs.svh"
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        dmareq, dmack_n, iord_n, intrq, slow;
	logic [15:0] dd_out, media_data, last_word;
	logic        media_req, media_lba, media_valid, media_err, power_down, auto_pd_on;
	logic [27:0] media_addr, err_sect, sa;
	logic [27:0] fetched[$];
	logic [7:0]  abort_ops[3] = '{8'h00, 8'hde, 8'hdf};
	int          nwords, failures, tests_run, base;

	ata_cmd #(.TICK_CYCLES(4), .DEV_NUM(1'b0)) i_ata_cmd (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dmareq(dmareq),
		.dmack_n(dmack_n), .iord_n(iord_n), .dd_out(dd_out), .intrq(intrq),
		.media_req(media_req), .media_addr(media_addr), .media_lba(media_lba),
		.media_valid(media_valid), .media_data(media_data), .media_err(media_err),
		.power_down(power_down), .auto_pd_on(auto_pd_on));
	dma_host i_dma_host (.pclk(pclk), .presetn(presetn), .dmareq(dmareq), .dd_out(dd_out),
		.slow(slow), .dmack_n(dmack_n), .iord_n(iord_n), .nwords(nwords),
		.last_word(last_word));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check(r, exp);
	endtask

	// command that ends two cycles after it is taken; status masked to bsy, drq, err
	task automatic cmd(input logic [7:0] op, input logic [7:0] exp_st);
		wr(`OFF_CMD, {24'h000000, op});
		repeat (2) @(posedge pclk);
		check({31'h0, intrq}, 32'h1);
		apb(1'b0, `OFF_CMD, 32'h00000000);
		check(r & 32'h89, {24'h0, exp_st});
	endtask

	task automatic dma(input logic [7:0] dh, input logic [7:0] sn, input logic [7:0] cnt,
			input logic [7:0] exp_st);
		wr(`OFF_DRVHD, {24'h0, dh});
		wr(`OFF_SCOUNT, {24'h0, cnt});
		wr(`OFF_SNUM, {24'h0, sn});
		wr(`OFF_CYLLO, 32'h0);
		wr(`OFF_CYLHI, 32'h0);
		fetched.delete();
		base = nwords;
		wr(`OFF_CMD, {24'h0, `CMD_RDDMA});
		apb(1'b0, `OFF_CMD, 32'h00000000);
		check(r & 32'h89, 32'h80);
		while (intrq !== 1'b1) begin
			@(posedge pclk);
		end
		apb(1'b0, `OFF_CMD, 32'h00000000);
		check(r & 32'h89, {24'h0, exp_st});
	endtask

	// media side: one sector of words per fetch, or an error on the chosen sector
	always @(posedge pclk) begin
		if (media_req === 1'b1) begin
			sa = media_addr;
			fetched.push_back(sa);
			if (sa === err_sect) begin
				media_err <= 1'b1;
				@(posedge pclk);
				media_err <= 1'b0;
			end else begin
				for (int k = 0; k < 256; k++) begin
					media_valid <= 1'b1;
					media_data <= {sa[7:0], 8'(k)};
					@(posedge pclk);
				end
				media_valid <= 1'b0;
			end
		end
	end

	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		finish_test();
	end

	initial begin
		{presetn, psel, penable, pwrite, media_valid, media_err, slow} = 7'h00;
		{paddr, pwdata, media_data} = 60'h0;
		{failures, tests_run} = 64'h0;
		err_sect = 28'hfffffff;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`OFF_GEOM, 32'h00000f3f);
		rd_chk(12'h0fc, 32'h0);
		check({31'h0, err}, 32'h1);
		wr(`OFF_SECURITY, 32'hffffffff);
		rd_chk(`OFF_SECURITY, 32'h0000013f);
		wr(`OFF_SECURITY, 32'h00000125);
		rd_chk(`OFF_SECURITY, 32'h00000125);
		for (int i = 0; i < 3; i++) begin
			cmd(abort_ops[i], 8'h01);
			rd_chk(`OFF_ERROR, 32'h04);
		end
		wr(`OFF_SCOUNT, 32'h3);
		cmd(`CMD_IDLE_A, 8'h00);
		rd_chk(`OFF_POWER, 32'h2);
		repeat (20) @(posedge pclk);
		rd_chk(`OFF_POWER, 32'h3);
		wr(`OFF_SCOUNT, 32'h0);
		cmd(`CMD_IDLEI_B, 8'h00);
		rd_chk(`OFF_POWER, 32'h2);
		cmd(`CMD_IDLE_B, 8'h00);
		cmd(`CMD_IDLEI_A, 8'h00);
		repeat (20) @(posedge pclk);
		rd_chk(`OFF_POWER, 32'h0);
		wr(`OFF_SCOUNT, 32'h11);
		wr(`OFF_SNUM, 32'h55);
		wr(`OFF_DRVHD, 32'ha5);
		cmd(`CMD_INIT, 8'h00);
		rd_chk(`OFF_GEOM, 32'h00000511);
		wr(`OFF_DRVHD, 32'hb0);
		wr(`OFF_CMD, 32'h0);
		repeat (4) @(posedge pclk);
		check({31'h0, intrq}, 32'h0);
		dma(8'ha0, 8'h11, 8'h02, 8'h00);
		check(32'(fetched.size()), 32'h2);
		check({4'h0, fetched[1]}, 32'h01000001);
		rd_chk(`OFF_SNUM, 32'h01);
		rd_chk(`OFF_DRVHD, 32'ha1);
		check(32'(nwords - base), 32'd512);
		check({16'h0, last_word}, 32'h01ff);
		slow <= 1'b1;
		// lba bit set by the host for block addressing
		dma(8'he3, 8'hfe, 8'h03, 8'h00);
		check({4'h0, fetched[2]}, 32'h03000100);
		check({31'h0, media_lba}, 32'h1);
		rd_chk(`OFF_SNUM, 32'h00);
		rd_chk(`OFF_CYLLO, 32'h01);
		check(32'(nwords - base), 32'd768);
		check({31'h0, dmareq}, 32'h0);
		cmd(`CMD_RDBUF, 8'h08);
		for (int k = 0; k < 256; k++) begin
			rd_chk(`OFF_DATA, 32'(k));
		end
		rd_chk(`OFF_CMD, 32'h40);
		err_sect = 28'h0000011;
		dma(8'he0, 8'h10, 8'h00, 8'h01);
		rd_chk(`OFF_ERROR, 32'h40);
		rd_chk(`OFF_SNUM, 32'h11);
		check(32'(fetched.size()), 32'h2);
		finish_test();
	end
endmodule
